// ===== lcs_pkg.sv
// Purpose: shared constants and types of the LIN configuration/status block
// Assumes: 200 MHz system clock, byte-wide register ports
// Notes:   all offsets, bit positions and timing figures live here
package lcs_pkg;
	localparam int unsigned CLK_HZ    = 200_000_000;
	localparam int unsigned BAUD_BPS  = 19_200;
	localparam int unsigned IDLE_TO_S = 4;

	localparam logic [7:0] CFG_ADDR  = 8'hc9;
	localparam logic [7:0] STAT_ADDR = 8'h09;
	localparam logic [7:0] CFG_RESET = 8'h60;
	localparam int         CFG_EN    = 7;
	localparam int         CFG_MODE  = 6;
	localparam int         CFG_AUTO  = 5;

	localparam int ST_ACTIVE = 7;
	localparam int ST_QUIET  = 6;
	localparam int ST_ABORT  = 5;
	localparam int ST_IDRX   = 4;
	localparam int ST_INT    = 3;
	localparam int ST_ERR    = 2;
	localparam int ST_WAKE   = 1;
	localparam int ST_DONE   = 0;

	localparam logic [7:0] SYNC_BYTE   = 8'h55;
	localparam logic [3:0] BRK_TX_BITS = 4'hd;
	localparam logic [7:0] BRK_RX_BITS = 8'h0b;
	localparam logic [3:0] BYTE_BITS   = 4'ha;
	localparam logic [3:0] RX_BITS     = 4'h9;
	localparam logic [2:0] AB_EDGES    = 3'h4;
	localparam int         AB_SHIFT    = 3;
	localparam logic [3:0] SIZE_BY_ID  = 4'hf;
	localparam logic [3:0] SIZE_MAX    = 4'h8;
	localparam logic [3:0] LEN_ID_LO   = 4'h2;
	localparam logic [3:0] LEN_ID_MID  = 4'h4;
	localparam logic [3:0] LEN_ID_HI   = 4'h8;

	typedef enum logic [2:0] {
		FR_IDLE = 3'b000,
		FR_BRK  = 3'b001,
		FR_SYNC = 3'b010,
		FR_PID  = 3'b011,
		FR_RESP = 3'b100,
		FR_WAKE = 3'b101
	} lcs_frame_e;

	typedef enum logic [1:0] {
		RX_WAIT_HI = 2'b00,
		RX_IDLE    = 2'b01,
		RX_START   = 2'b10,
		RX_BITS_S  = 2'b11
	} lcs_rx_e;
endpackage

// ===== lcs_byte_if.sv
// Purpose: carries byte traffic between frame control and the bit engine
// Assumes: single clock domain
// Notes:   pulses last one cycle
interface lcs_byte_if;
	logic        en;
	logic [15:0] bit_cyc;
	logic        rx_line;
	logic        tx_dom;
	logic        tx_start;
	logic        tx_break;
	logic [7:0]  tx_byte;
	logic        tx_busy;
	logic        tx_done;
	logic        rx_flush;
	logic        rx_valid;
	logic [7:0]  rx_byte;
	logic        rx_ferr;
	logic        rx_break;
	logic        bit_err;
	modport eng (input en, bit_cyc, rx_line, tx_start, tx_break, tx_byte, rx_flush,
		output tx_dom, tx_busy, tx_done, rx_valid, rx_byte, rx_ferr, rx_break, bit_err);
	modport ctl (output en, bit_cyc, rx_line, tx_start, tx_break, tx_byte, rx_flush,
		input tx_dom, tx_busy, tx_done, rx_valid, rx_byte, rx_ferr, rx_break, bit_err);
endinterface

// ===== lcs_byte_engine.sv
// Purpose: serialises bytes and breaks, deserialises bytes, spots breaks
// Assumes: rx_line already synchronous to clk
// Notes:   a zero byte with a bad stop bit is taken as a break start
module lcs_byte_engine
(
	input  wire logic clk,     // system clock
	input  wire logic reset_n, // synchronous reset
	lcs_byte_if.eng   eng      // link to frame control
);
	import lcs_pkg::*;

	logic [15:0] tx_cnt_r, tx_cnt_nxt;
	logic [3:0]  tx_n_r, tx_n_nxt;
	logic [13:0] tx_sh_r, tx_sh_nxt;
	logic        tx_dom_r, tx_dom_nxt, tx_done_r, tx_done_nxt, berr_r, berr_nxt;
	lcs_rx_e     rx_st_r, rx_st_nxt;
	logic [15:0] rx_cnt_r, rx_cnt_nxt;
	logic [3:0]  rx_n_r, rx_n_nxt;
	logic [7:0]  rx_sh_r, rx_sh_nxt, rx_byte_r, rx_byte_nxt;
	logic [23:0] low_r, low_nxt, brk_lim;
	logic        rv_r, rv_nxt, fe_r, fe_nxt, brk_r, brk_nxt;

	assign brk_lim = 24'(eng.bit_cyc) * 24'(BRK_RX_BITS);
	assign eng.tx_busy = (tx_n_r != 4'h0);
	assign eng.tx_dom = tx_dom_r;
	assign eng.tx_done = tx_done_r;
	assign eng.bit_err = berr_r;
	assign eng.rx_valid = rv_r;
	assign eng.rx_byte = rx_byte_r;
	assign eng.rx_ferr = fe_r;
	assign eng.rx_break = brk_r;

	always_comb
	begin
		tx_cnt_nxt = tx_cnt_r;
		tx_n_nxt = tx_n_r;
		tx_sh_nxt = tx_sh_r;
		tx_dom_nxt = tx_dom_r;
		tx_done_nxt = 1'b0;
		berr_nxt = 1'b0;
		if (!eng.en)
		begin
			tx_n_nxt = 4'h0;
			tx_dom_nxt = 1'b0;
		end
		else if (tx_n_r == 4'h0)
		begin
			if (eng.tx_start || eng.tx_break)
			begin
				// Break: 13 dominant bits, then one recessive delimiter
				tx_sh_nxt = eng.tx_break ? {1'b1, 13'h0000} : {5'h1f, eng.tx_byte, 1'b0};
				tx_n_nxt = eng.tx_break ? BRK_TX_BITS + 4'h1 : BYTE_BITS;
				tx_cnt_nxt = eng.bit_cyc - 16'h0001;
				tx_dom_nxt = 1'b1;
			end
		end
		else
		begin
			// Recessive sent but dominant read back: another node fights us
			if (tx_cnt_r == (eng.bit_cyc >> 1) && !tx_dom_r && !eng.rx_line)
				berr_nxt = 1'b1;
			if (tx_cnt_r != 16'h0000)
				tx_cnt_nxt = tx_cnt_r - 16'h0001;
			else if (tx_n_r == 4'h1)
			begin
				tx_n_nxt = 4'h0;
				tx_dom_nxt = 1'b0;
				tx_done_nxt = 1'b1;
			end
			else
			begin
				tx_sh_nxt = tx_sh_r >> 1;
				tx_n_nxt = tx_n_r - 4'h1;
				tx_dom_nxt = !tx_sh_r[1];
				tx_cnt_nxt = eng.bit_cyc - 16'h0001;
			end
		end
	end

	always_comb
	begin
		rx_st_nxt = rx_st_r;
		rx_cnt_nxt = rx_cnt_r;
		rx_n_nxt = rx_n_r;
		rx_sh_nxt = rx_sh_r;
		rx_byte_nxt = rx_byte_r;
		rv_nxt = 1'b0;
		fe_nxt = 1'b0;
		brk_nxt = 1'b0;
		low_nxt = (eng.rx_line || !eng.en) ? 24'h000000 : low_r;
		if (!eng.rx_line && eng.en && low_r != brk_lim)
		begin
			low_nxt = low_r + 24'h000001;
			brk_nxt = (low_r == brk_lim - 24'h000001);
		end
		if (!eng.en || eng.rx_flush || brk_nxt)
			rx_st_nxt = RX_WAIT_HI;
		else
			case (rx_st_r)
				RX_WAIT_HI: if (eng.rx_line) rx_st_nxt = RX_IDLE;
				RX_IDLE:
					if (!eng.rx_line)
					begin
						rx_st_nxt = RX_START;
						rx_cnt_nxt = eng.bit_cyc >> 1;
					end
				RX_START:
					if (rx_cnt_r != 16'h0000)
						rx_cnt_nxt = rx_cnt_r - 16'h0001;
					else
					begin
						rx_st_nxt = eng.rx_line ? RX_IDLE : RX_BITS_S;
						rx_n_nxt = RX_BITS;
						rx_cnt_nxt = eng.bit_cyc - 16'h0001;
					end
				RX_BITS_S:
					if (rx_cnt_r != 16'h0000)
						rx_cnt_nxt = rx_cnt_r - 16'h0001;
					else if (rx_n_r == 4'h1)
					begin
						rv_nxt = eng.rx_line;
						fe_nxt = !eng.rx_line && rx_sh_r != 8'h00;
						rx_byte_nxt = rx_sh_r;
						rx_st_nxt = eng.rx_line ? RX_IDLE : RX_WAIT_HI;
					end
					else
					begin
						rx_sh_nxt = {eng.rx_line, rx_sh_r[7:1]};
						rx_n_nxt = rx_n_r - 4'h1;
						rx_cnt_nxt = eng.bit_cyc - 16'h0001;
					end
				default: rx_st_nxt = RX_WAIT_HI;
			endcase
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			tx_cnt_r <= 16'h0000;
			tx_n_r <= 4'h0;
			tx_sh_r <= 14'h0000;
			tx_dom_r <= 1'b0;
			tx_done_r <= 1'b0;
			berr_r <= 1'b0;
			rx_st_r <= RX_WAIT_HI;
			rx_cnt_r <= 16'h0000;
			rx_n_r <= 4'h0;
			rx_sh_r <= 8'h00;
			rx_byte_r <= 8'h00;
			low_r <= 24'h000000;
			rv_r <= 1'b0;
			fe_r <= 1'b0;
			brk_r <= 1'b0;
		end
		else
		begin
			tx_cnt_r <= tx_cnt_nxt;
			tx_n_r <= tx_n_nxt;
			tx_sh_r <= tx_sh_nxt;
			tx_dom_r <= tx_dom_nxt;
			tx_done_r <= tx_done_nxt;
			berr_r <= berr_nxt;
			rx_st_r <= rx_st_nxt;
			rx_cnt_r <= rx_cnt_nxt;
			rx_n_r <= rx_n_nxt;
			rx_sh_r <= rx_sh_nxt;
			rx_byte_r <= rx_byte_nxt;
			low_r <= low_nxt;
			rv_r <= rv_nxt;
			fe_r <= fe_nxt;
			brk_r <= brk_nxt;
		end
	end
endmodule // lcs_byte_engine

// ===== lcs_top.sv
// Purpose: LIN controller configuration, status flags and frame sequencing
// Assumes: control bits (stop, interrupt reset, error reset) arrive as pulses
// Notes:   checksum is passed through, not checked
module lcs_top
#(
	parameter int unsigned BIT_CYC  = lcs_pkg::CLK_HZ / lcs_pkg::BAUD_BPS,
	parameter int unsigned IDLE_CYC = lcs_pkg::IDLE_TO_S * lcs_pkg::CLK_HZ
)
(
	input  wire logic       clk,                 // system clock
	input  wire logic       reset_n,             // synchronous reset
	input  wire logic [7:0] sfr_addr,            // direct register address
	input  wire logic       sfr_wr,              // direct write strobe
	input  wire logic       sfr_rd,              // direct read strobe
	input  wire logic [7:0] sfr_wdata,           // direct write data
	output logic      [7:0] sfr_rdata,           // direct read data
	input  wire logic [7:0] ind_addr,            // indirect register address
	input  wire logic       ind_rd,              // indirect read strobe
	output logic      [7:0] ind_rdata,           // indirect read data
	input  wire logic       stop_bit,            // stop request pulse
	input  wire logic       interrupt_reset_bit, // clear pending interrupt
	input  wire logic       error_reset_bit,     // clear error flag
	input  wire logic       start_req,           // master frame start pulse
	input  wire logic       wake_req,            // send wakeup pulse
	input  wire logic [5:0] frame_id,            // identifier to send
	input  wire logic [3:0] frame_size,          // data byte count code
	output logic            rx_data_valid,       // response byte strobe
	output logic      [7:0] rx_data,             // response byte
	input  wire logic       lin_rx,              // bus level
	output logic            lin_tx_out,          // bus drive level
	output logic            lin_tx_oe,           // bus drive enable
	output logic            lin_irq              // interrupt request
);
	import lcs_pkg::*;

	lcs_byte_if eng ();

	lcs_frame_e  st_r, st_nxt;
	logic [3:0]  cnt_r, cnt_nxt;
	logic [19:0] ab_cnt_r, ab_cnt_nxt;
	logic [2:0]  ab_fall_r, ab_fall_nxt;
	logic [15:0] ab_bit_r, ab_bit_nxt;
	logic        rx_d_r;
	logic        abort_r, abort_nxt, idrx_r, idrx_nxt, int_r, int_nxt;
	logic        err_r, err_nxt, done_r, done_nxt, wrx_r, wrx_nxt;
	logic        quiet_r, quiet_nxt;
	logic [29:0] idle_r, idle_nxt;
	logic [2:0]  cfg_r, cfg_nxt;
	logic [7:0]  srd_r, srd_nxt, ird_r, ird_nxt, rxd_r, rxd_nxt;
	logic        rxv_r, rxv_nxt;
	logic        en, master, slave, autobaud_on, fall;
	logic        ev_start, ev_done, ev_idrx, ev_err, ev_abort, ev_clr, ev_wake;
	logic [7:0]  status;

	function automatic logic [7:0] prot_id(input logic [5:0] id);
		prot_id = {!(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
	endfunction

	function automatic logic [3:0] data_len(input logic [3:0] sz, input logic [5:0] id);
		if (sz == SIZE_BY_ID)
			data_len = id[5] ? (id[4] ? LEN_ID_HI : LEN_ID_MID) : LEN_ID_LO;
		else
			data_len = (sz > SIZE_MAX) ? SIZE_MAX : sz;
	endfunction

	assign en = cfg_r[CFG_EN - CFG_AUTO];
	assign master = cfg_r[CFG_MODE - CFG_AUTO];
	assign slave = !master;
	assign autobaud_on = slave && cfg_r[0];
	assign fall = rx_d_r && !lin_rx;

	assign eng.en = en;
	assign eng.bit_cyc = autobaud_on ? ab_bit_r : 16'(BIT_CYC);
	assign eng.rx_line = lin_rx;
	assign lin_tx_out = 1'b0;
	assign lin_tx_oe = eng.tx_dom;
	assign lin_irq = int_r;

	lcs_byte_engine u_eng
	(
		.clk     (clk),
		.reset_n (reset_n),
		.eng     (eng)
	);

	// Frame sequencing
	always_comb
	begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		ab_cnt_nxt = ab_cnt_r;
		ab_fall_nxt = ab_fall_r;
		ab_bit_nxt = ab_bit_r;
		eng.tx_start = 1'b0;
		eng.tx_break = 1'b0;
		eng.tx_byte = SYNC_BYTE;
		eng.rx_flush = 1'b0;
		{ev_start, ev_done, ev_idrx, ev_err, ev_abort, ev_clr} = 6'h00;
		if (!en)
			st_nxt = FR_IDLE;
		else if (stop_bit)
		begin
			st_nxt = FR_IDLE;
			ev_abort = slave;
		end
		else if (slave && eng.rx_break)
		begin
			ev_start = 1'b1;
			eng.rx_flush = 1'b1;
			ev_abort = (st_r != FR_IDLE);
			ev_clr = (st_r == FR_IDLE);
			st_nxt = FR_SYNC;
			ab_cnt_nxt = 20'h00000;
			ab_fall_nxt = 3'h0;
		end
		else
		begin
			case (st_r)
				FR_IDLE:
					if (master && start_req)
					begin
						st_nxt = FR_BRK;
						eng.tx_break = 1'b1;
						ev_start = 1'b1;
					end
					else if (wake_req && !eng.tx_busy)
					begin
						st_nxt = FR_WAKE;
						eng.tx_break = 1'b1;
					end
				FR_BRK:
					if (eng.tx_done)
					begin
						st_nxt = FR_SYNC;
						eng.tx_start = 1'b1;
					end
				FR_SYNC:
					if (autobaud_on)
					begin
						// Fifth falling edge of 0x55 lies eight bit times after the first
						if (ab_fall_r != 3'h0)
							ab_cnt_nxt = ab_cnt_r + 20'h00001;
						if (fall)
						begin
							ab_fall_nxt = ab_fall_r + 3'h1;
							if (ab_fall_r == AB_EDGES)
							begin
								// Count including this cycle, else one cycle short per bit
								ab_bit_nxt = ab_cnt_nxt[AB_SHIFT +: 16];
								eng.rx_flush = 1'b1;
								st_nxt = FR_PID;
							end
						end
					end
					else if (master)
					begin
						// Sync echo lands mid stop bit while the sender is still busy
						if (eng.tx_done)
						begin
							st_nxt = FR_PID;
							eng.tx_start = 1'b1;
							eng.tx_byte = prot_id(frame_id);
						end
					end
					else if (eng.rx_valid)
					begin
						st_nxt = (eng.rx_byte == SYNC_BYTE) ? FR_PID : FR_IDLE;
						ev_err = (eng.rx_byte != SYNC_BYTE);
					end
				FR_PID:
					if (eng.rx_valid)
					begin
						cnt_nxt = data_len(frame_size, eng.rx_byte[5:0]);
						if (slave && eng.rx_byte != prot_id(eng.rx_byte[5:0]))
						begin
							ev_err = 1'b1;
							st_nxt = FR_IDLE;
						end
						else
						begin
							ev_idrx = slave;
							st_nxt = FR_RESP;
						end
					end
				FR_RESP:
					if (eng.rx_valid)
					begin
						if (cnt_r == 4'h0)
						begin
							ev_done = 1'b1;
							st_nxt = FR_IDLE;
						end
						else
							cnt_nxt = cnt_r - 4'h1;
					end
				FR_WAKE:
					if (eng.tx_done)
						st_nxt = FR_IDLE;
				default: st_nxt = FR_IDLE;
			endcase
			if (eng.rx_ferr || eng.bit_err)
			begin
				ev_err = 1'b1;
				st_nxt = FR_IDLE;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			st_r <= FR_IDLE;
			cnt_r <= 4'h0;
			ab_cnt_r <= 20'h00000;
			ab_fall_r <= 3'h0;
			ab_bit_r <= 16'(BIT_CYC);
			rx_d_r <= 1'b1;
		end
		else
		begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			ab_cnt_r <= ab_cnt_nxt;
			ab_fall_r <= ab_fall_nxt;
			ab_bit_r <= ab_bit_nxt;
			rx_d_r <= lin_rx;
		end
	end

	// Status flags: a set in the same cycle as its clear always wins
	always_comb
	begin
		quiet_nxt = 1'b0;
		idle_nxt = 30'h00000000;
		if (en && lin_rx && st_r == FR_IDLE)
		begin
			quiet_nxt = (idle_r == 30'(IDLE_CYC - 1));
			idle_nxt = quiet_nxt ? idle_r : idle_r + 30'h00000001;
		end
		ev_wake = quiet_r && fall && st_r == FR_IDLE;
		abort_nxt = slave && (ev_abort || (abort_r && !ev_clr));
		idrx_nxt = slave && (ev_idrx || (idrx_r && !ev_start));
		done_nxt = ev_done || (done_r && !ev_start);
		err_nxt = ev_err || (err_r && !error_reset_bit);
		wrx_nxt = ev_wake || (wrx_r && !ev_start);
		int_nxt = ev_done || ev_err || ev_idrx || ev_abort || ev_wake
			|| (slave && quiet_nxt && !quiet_r) || (int_r && !interrupt_reset_bit);
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			{abort_r, idrx_r, done_r, err_r, wrx_r, int_r, quiet_r} <= 7'h00;
			idle_r <= 30'h00000000;
		end
		else
		begin
			abort_r <= abort_nxt;
			idrx_r <= idrx_nxt;
			done_r <= done_nxt;
			err_r <= err_nxt;
			wrx_r <= wrx_nxt;
			int_r <= int_nxt;
			quiet_r <= quiet_nxt;
			idle_r <= idle_nxt;
		end
	end

	assign status[ST_ACTIVE] = (st_r != FR_IDLE) || !lin_rx;
	assign status[ST_QUIET] = quiet_r && slave;
	assign status[ST_ABORT] = abort_r;
	assign status[ST_IDRX] = idrx_r;
	assign status[ST_INT] = int_r;
	assign status[ST_ERR] = err_r;
	assign status[ST_WAKE] = (st_r == FR_WAKE) || wrx_r;
	assign status[ST_DONE] = done_r;

	// Register access; the status port has no write path at all
	always_comb
	begin
		cfg_nxt = cfg_r;
		if (sfr_wr && sfr_addr == CFG_ADDR)
			cfg_nxt = sfr_wdata[CFG_EN:CFG_AUTO];
		srd_nxt = (sfr_rd && sfr_addr == CFG_ADDR) ? {cfg_r, 5'h00} : 8'h00;
		ird_nxt = (ind_rd && ind_addr == STAT_ADDR) ? status : 8'h00;
		rxv_nxt = (st_r == FR_RESP) && eng.rx_valid;
		rxd_nxt = rxv_nxt ? eng.rx_byte : rxd_r;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			cfg_r <= CFG_RESET[CFG_EN:CFG_AUTO];
			srd_r <= 8'h00;
			ird_r <= 8'h00;
			rxv_r <= 1'b0;
			rxd_r <= 8'h00;
		end
		else
		begin
			cfg_r <= cfg_nxt;
			srd_r <= srd_nxt;
			ird_r <= ird_nxt;
			rxv_r <= rxv_nxt;
			rxd_r <= rxd_nxt;
		end
	end

	assign sfr_rdata = srd_r;
	assign ind_rdata = ird_r;
	assign rx_data_valid = rxv_r;
	assign rx_data = rxd_r;

	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence slave_break_s;
		en && slave && !stop_bit && eng.rx_break;
	endsequence
	sequence master_start_s;
		en && master && !stop_bit && st_r == FR_IDLE && start_req;
	endsequence

	cfg_low_zero_a: assert property (sfr_rd && sfr_addr == CFG_ADDR |=> sfr_rdata[4:0] == 5'h00)
		else $error("config low bits not zero");
	disabled_idle_a: assert property (!en |=> st_r == FR_IDLE)
		else $error("frame engine runs while disabled");
	master_flags_a: assert property (master |-> !abort_r && !idrx_r && !status[ST_QUIET])
		else $error("slave-only flag set in master role");
	stop_abort_a: assert property (en && slave && stop_bit |=> abort_r)
		else $error("stop did not abort");
	done_clear_a: assert property (slave_break_s or master_start_s |=> !done_r)
		else $error("done not cleared at frame start");
	err_hold_a: assert property (err_r && !error_reset_bit |=> err_r [*1])
		else $error("error flag lost without reset");
	int_clear_a: assert property (int_r && interrupt_reset_bit && !int_nxt |=> !lin_irq)
		else $error("interrupt not cleared");
	irq_read_a: assert property (ind_rd && ind_addr == STAT_ADDR |=> ind_rdata[ST_INT] == $past(lin_irq))
		else $error("irq line and status disagree");
	baud_master_a: assert property (master |-> eng.bit_cyc == 16'(BIT_CYC))
		else $error("auto baud used in master role");
	active_a: assert property (st_r != FR_IDLE |-> status[ST_ACTIVE])
		else $error("activity flag low during frame");
endmodule // lcs_top

// ===== lcs_node.sv
// Purpose: far-side LIN node model that pulls the shared wire low
// Assumes: the wire has a pull-up, so a released node reads recessive
// Notes:   bit time is a parameter in system clock cycles
module lcs_node
#(
	parameter int unsigned BIT = 16
)
(
	input  wire logic clk,     // system clock
	output logic      pull_low // node drives bus dominant
);
	timeunit 1ns;
	timeprecision 1ps;
	import lcs_pkg::*;

	initial pull_low = 1'b0;

	task automatic level(input logic v, input int n);
		pull_low = !v;
		repeat (n * BIT) @(negedge clk);
	endtask

	// Stop value is a knob so a scenario can commit a framing fault
	task automatic send_byte(input logic [7:0] b, input logic stop);
		level(1'b0, 1);
		for (int i = 0; i < 8; i++)
			level(b[i], 1);
		level(stop, 1);
		pull_low = 1'b0;
	endtask

	task automatic brk();
		level(1'b0, 13);
		level(1'b1, 1);
	endtask
endmodule // lcs_node

// ===== tb.sv
// Purpose: self-checking bench for the LIN configuration/status block
// Assumes: inputs change on the falling clock edge
// Notes:   short bit time and idle timeout keep the run brief
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import lcs_pkg::*;

	localparam int BIT = 16;
	localparam int IDL = 200;
	localparam int HEAD = 34 * BIT + 20;

	logic       clk;
	logic       reset_n;
	logic [7:0] sfr_addr;
	logic       sfr_wr;
	logic       sfr_rd;
	logic [7:0] sfr_wdata;
	logic [7:0] ind_addr;
	logic       ind_rd;
	logic       stop_bit;
	logic       irb;
	logic       erb;
	logic       start_req;
	logic       wake_req;
	logic [5:0] frame_id;
	logic [3:0] frame_size;
	wire  [7:0] sfr_rdata;
	wire  [7:0] ind_rdata;
	wire        rx_data_valid;
	wire  [7:0] rx_data;
	wire        lin_tx_out;
	wire        lin_tx_oe;
	wire        lin_irq;
	wire        pull_low;
	wire        lin_rx;
	int         miscompares;
	int         num_checks;

	// Wired-AND bus with pull-up
	assign lin_rx = !(lin_tx_oe && !lin_tx_out) && !pull_low;

	lcs_top #(.BIT_CYC(BIT), .IDLE_CYC(IDL)) dut
	(
		.clk                 (clk),
		.reset_n             (reset_n),
		.sfr_addr            (sfr_addr),
		.sfr_wr              (sfr_wr),
		.sfr_rd              (sfr_rd),
		.sfr_wdata           (sfr_wdata),
		.sfr_rdata           (sfr_rdata),
		.ind_addr            (ind_addr),
		.ind_rd              (ind_rd),
		.ind_rdata           (ind_rdata),
		.stop_bit            (stop_bit),
		.interrupt_reset_bit (irb),
		.error_reset_bit     (erb),
		.start_req           (start_req),
		.wake_req            (wake_req),
		.frame_id            (frame_id),
		.frame_size          (frame_size),
		.rx_data_valid       (rx_data_valid),
		.rx_data             (rx_data),
		.lin_rx              (lin_rx),
		.lin_tx_out          (lin_tx_out),
		.lin_tx_oe           (lin_tx_oe),
		.lin_irq             (lin_irq)
	);

	lcs_node #(.BIT(BIT)) node
	(
		.clk      (clk),
		.pull_low (pull_low)
	);

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clk);
		sfr_wr = 1'b0;
	endtask

	task automatic rd(input logic ind, input logic [7:0] a, input logic [7:0] m,
		input logic [7:0] exp);
		sfr_addr = a;
		ind_addr = a;
		sfr_rd = !ind;
		ind_rd = ind;
		@(negedge clk);
		sfr_rd = 1'b0;
		ind_rd = 1'b0;
		chk(ind ? "status" : "sfr", exp, (ind ? ind_rdata : sfr_rdata) & m);
	endtask

	task automatic st(input logic [7:0] m, input logic [7:0] exp);
		rd(1'b1, STAT_ADDR, m, exp);
	endtask

	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
		@(negedge clk);
	endtask

	// Waits for one received byte; a missing strobe shows as a mismatch
	task automatic wait_rx(input logic [7:0] exp);
		int n;
		n = 0;
		while (rx_data_valid !== 1'b1 && n < 40 * BIT)
		begin
			@(negedge clk);
			n++;
		end
		chk("rx_valid", 8'h01, {7'h00, rx_data_valid});
		chk("rx_data", exp, rx_data);
	endtask

	function automatic logic [7:0] pid(input logic [5:0] id);
		return {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
	endfunction

	task automatic head(input logic [7:0] p);
		node.brk();
		node.send_byte(SYNC_BYTE, 1'b1);
		node.send_byte(p, 1'b1);
	endtask

	initial
	begin
		repeat (20000) @(posedge clk);
		miscompares++;
		print_verdict();
	end

	initial
	begin
		{reset_n, sfr_wr, sfr_rd, ind_rd, stop_bit, irb, erb, start_req, wake_req} = '0;
		{sfr_addr, sfr_wdata, ind_addr} = '0;
		frame_id = 6'h3c;
		frame_size = 4'h0;
		miscompares = 0;
		num_checks = 0;
		repeat (2) @(negedge clk);
		reset_n = 1'b1;
		rd(1'b0, CFG_ADDR, 8'hff, CFG_RESET);
		st(8'hff, 8'h00);
		rd(1'b0, 8'h12, 8'hff, 8'h00);
		wr(STAT_ADDR, 8'hff);
		st(8'hff, 8'h00);
		wr(CFG_ADDR, 8'h7f);
		rd(1'b0, CFG_ADDR, 8'hff, 8'h60);
		pulse(start_req);
		repeat (5) @(negedge clk);
		chk("oe_off", 8'h00, {7'h00, lin_tx_oe});
		wr(CFG_ADDR, 8'hff);
		rd(1'b0, CFG_ADDR, 8'hff, 8'he0);
		// Master with auto baud set: the bit must not matter
		pulse(start_req);
		chk("oe_brk", 8'h01, {7'h00, lin_tx_oe});
		st(8'h81, 8'h80);
		repeat (HEAD) @(negedge clk);
		fork
			node.send_byte(8'h5a, 1'b1);
			wait_rx(8'h5a);
		join
		repeat (BIT) @(negedge clk);
		st(8'h8f, 8'h09);
		chk("irq_on", 8'h01, {7'h00, lin_irq});
		pulse(irb);
		chk("irq_off", 8'h00, {7'h00, lin_irq});
		st(8'h08, 8'h00);
		pulse(start_req);
		st(8'h01, 8'h00);
		repeat (HEAD) @(negedge clk);
		node.send_byte(8'h5a, 1'b0);
		repeat (BIT) @(negedge clk);
		st(8'h04, 8'h04);
		pulse(erb);
		st(8'h04, 8'h00);
		pulse(wake_req);
		repeat (4) @(negedge clk);
		st(8'h02, 8'h02);
		repeat (15 * BIT) @(negedge clk);
		pulse(irb);
		wr(CFG_ADDR, 8'h80);
		rd(1'b0, CFG_ADDR, 8'hff, 8'h80);
		head(pid(6'h10));
		repeat (BIT) @(negedge clk);
		st(8'h10, 8'h10);
		node.brk();
		st(8'h20, 8'h20);
		node.send_byte(SYNC_BYTE, 1'b1);
		node.send_byte(pid(6'h10), 1'b1);
		fork
			node.send_byte(8'h33, 1'b1);
			wait_rx(8'h33);
		join
		repeat (BIT) @(negedge clk);
		st(8'h21, 8'h21);
		wr(CFG_ADDR, 8'ha0);
		head(pid(6'h10));
		repeat (BIT) @(negedge clk);
		st(8'h30, 8'h10);
		fork
			node.send_byte(8'h44, 1'b1);
			wait_rx(8'h44);
		join
		pulse(irb);
		repeat (IDL + 2 * BIT) @(negedge clk);
		st(8'h40, 8'h40);
		chk("irq_idle", 8'h01, {7'h00, lin_irq});
		node.level(1'b0, 4);
		node.level(1'b1, 1);
		st(8'h02, 8'h02);
		pulse(stop_bit);
		st(8'h20, 8'h20);
		print_verdict();
	end
endmodule // tb
